// file: logic/rff_top.sv
// Measurement frame formatter: builds frames into a byte FIFO
`default_nettype none
module rff_top
  import rff_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        meas_valid_in,
  output logic             meas_ready_out,
  input  wire logic [15:0] meas_dist_cm_in,
  input  wire logic [15:0] meas_dist_mm_in,
  input  wire logic [15:0] meas_strength_in,
  input  wire logic        meas_overexp_in,
  input  wire logic [15:0] meas_temp_raw_in,
  input  wire logic [31:0] meas_time_ms_in,
  input  wire logic [7:0]  cfg_format_in,
  input  wire logic        cfg_format_we_in,
  input  wire logic        cfg_out_en_in,
  input  wire logic        cfg_out_en_we_in,
  input  wire logic [6:0]  cfg_i2c_addr_in,
  output logic [7:0]       cfg_format_out,
  output logic             cfg_out_en_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic [7:0]       tx_data_out,
  output logic             busy_out
);
  import rff_pkg::*;

  rff_byte_if #(.W(RFF_BYTE_W)) bus ();

  logic [7:0]   fmt_reg;
  logic         en_reg;
  rff_state_e   st_reg;
  logic [4:0]   idx_reg;
  logic [4:0]   len_reg;
  logic [7:0]   sum_reg;
  logic [7:0]   fmt_cap_reg;
  logic [15:0]  dist_reg;
  logic [15:0]  amp_reg;
  logic [15:0]  temp_reg;
  logic [31:0]  ts_reg;
  logic [7:0]   tag_reg;
  logic [7:0]   txt_reg [4];

  // Known layout codes; unknown codes keep the current layout
  function automatic logic fmt_known(input logic [7:0] f);
    fmt_known = (f == RFF_FMT_CM9) || (f == RFF_FMT_TEXT) ||
                (f == RFF_FMT_MM9) || (f == RFF_FMT_TS) ||
                (f == RFF_FMT_LEN) || (f == RFF_FMT_EIGHT) ||
                (f == RFF_FMT_TAG);
  endfunction

  function automatic logic [4:0] fmt_len(input logic [7:0] f);
    unique case (f)
      RFF_FMT_TEXT:  fmt_len = RFF_LEN_TEXT;
      RFF_FMT_TS:    fmt_len = RFF_LEN_TS;
      RFF_FMT_LEN:   fmt_len = RFF_LEN_LP;
      RFF_FMT_EIGHT: fmt_len = RFF_LEN_EIGHT;
      RFF_FMT_TAG:   fmt_len = RFF_LEN_TAG;
      default:       fmt_len = RFF_LEN_NINE;
    endcase
  endfunction

  // Distance in centimetres to ASCII "X.YZ"; metres digit saturates at 9
  wire [15:0] cm_val   = meas_dist_cm_in;
  wire [15:0] m_whole  = cm_val / 16'd100;
  wire [15:0] cm_rem   = cm_val % 16'd100;
  wire [3:0]  m_dig    = (m_whole > 16'd9) ? 4'd9 : m_whole[3:0];
  wire [15:0] tens_w   = cm_rem / 16'd10;
  wire [15:0] ones_w   = cm_rem % 16'd10;

  wire        start   = (st_reg == RFF_IDLE) && meas_valid_in && en_reg;
  wire        sending = (st_reg == RFF_SEND);
  wire        last    = (idx_reg == len_reg - 5'd1);
  wire        beat    = sending && bus.ready;
  wire [15:0] amp_in  = meas_overexp_in ? RFF_OVEREXP
                                        : meas_strength_in;
  wire        is_mm   = (fmt_reg == RFF_FMT_MM9);

  // Byte selection for the current position of the current layout
  logic [7:0] body_byte;
  logic       sum_slot;
  always_comb begin
    body_byte = 8'h00;
    sum_slot  = 1'b0;
    unique case (fmt_cap_reg)
      RFF_FMT_TEXT: begin
        body_byte = (idx_reg == 5'd1) ? RFF_ASCII_DOT :
                    (idx_reg == 5'd5) ? RFF_TERM_CHAR :
                    (idx_reg == 5'd0) ? txt_reg[0] :
                    (idx_reg == 5'd2) ? txt_reg[1] :
                    (idx_reg == 5'd3) ? txt_reg[2] : txt_reg[3];
      end
      RFF_FMT_EIGHT: begin
        unique case (idx_reg)
          5'd0:    body_byte = dist_reg[7:0];
          5'd1:    body_byte = dist_reg[15:8];
          5'd2:    body_byte = amp_reg[7:0];
          5'd3:    body_byte = amp_reg[15:8];
          5'd4:    body_byte = ts_reg[7:0];
          5'd5:    body_byte = ts_reg[15:8];
          5'd6:    body_byte = ts_reg[23:16];
          default: body_byte = ts_reg[31:24];
        endcase
      end
      RFF_FMT_TS: begin
        sum_slot = (idx_reg == 5'd10);
        unique case (idx_reg)
          5'd0, 5'd1: body_byte = RFF_HDR_NINE;
          5'd2:    body_byte = dist_reg[7:0];
          5'd3:    body_byte = dist_reg[15:8];
          5'd4:    body_byte = amp_reg[7:0];
          5'd5:    body_byte = amp_reg[15:8];
          5'd6:    body_byte = ts_reg[7:0];
          5'd7:    body_byte = ts_reg[15:8];
          5'd8:    body_byte = ts_reg[23:16];
          default: body_byte = ts_reg[31:24];
        endcase
      end
      RFF_FMT_LEN, RFF_FMT_TAG: begin
        sum_slot = last;
        unique case (idx_reg)
          5'd0:    body_byte = RFF_HDR_LEN;
          5'd1:    body_byte = {3'b000, len_reg};
          5'd2:    body_byte = RFF_ZERO_ID;
          5'd3:    body_byte = dist_reg[7:0];
          5'd4:    body_byte = dist_reg[15:8];
          5'd5:    body_byte = amp_reg[7:0];
          5'd6:    body_byte = amp_reg[15:8];
          5'd7:    body_byte = ts_reg[7:0];
          5'd8:    body_byte = ts_reg[15:8];
          5'd9:    body_byte = ts_reg[23:16];
          5'd10:   body_byte = ts_reg[31:24];
          default: body_byte = tag_reg;
        endcase
      end
      default: begin
        sum_slot = (idx_reg == 5'd8);
        unique case (idx_reg)
          5'd0, 5'd1: body_byte = RFF_HDR_NINE;
          5'd2:    body_byte = dist_reg[7:0];
          5'd3:    body_byte = dist_reg[15:8];
          5'd4:    body_byte = amp_reg[7:0];
          5'd5:    body_byte = amp_reg[15:8];
          5'd6:    body_byte = temp_reg[7:0];
          default: body_byte = temp_reg[15:8];
        endcase
      end
    endcase
  end

  wire [7:0] out_byte = sum_slot ? sum_reg : body_byte;

  assign bus.valid      = sending;
  assign bus.data       = out_byte;
  assign meas_ready_out = (st_reg == RFF_IDLE);
  assign busy_out       = sending;
  assign cfg_format_out = fmt_reg;
  assign cfg_out_en_out = en_reg;

  // Configuration registers
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fmt_reg <= RFF_FMT_RESET;
      en_reg  <= RFF_EN_RESET;
    end else begin
      if (cfg_format_we_in && fmt_known(cfg_format_in)) begin
        fmt_reg <= cfg_format_in;
      end
      if (cfg_out_en_we_in) begin
        en_reg <= cfg_out_en_in;
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg      <= RFF_IDLE;
      idx_reg     <= 5'd0;
      len_reg     <= RFF_LEN_NINE;
      sum_reg     <= 8'h00;
      fmt_cap_reg <= RFF_FMT_RESET;
    end else begin
      unique case (st_reg)
        RFF_IDLE: begin
          if (start) begin
            st_reg      <= RFF_SEND;
            idx_reg     <= 5'd0;
            sum_reg     <= 8'h00;
            fmt_cap_reg <= fmt_reg;
            len_reg     <= fmt_len(fmt_reg);
          end
        end
        RFF_SEND: begin
          if (beat) begin
            sum_reg <= sum_reg + out_byte;
            idx_reg <= idx_reg + 5'd1;
            if (last) begin
              st_reg <= RFF_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Sample snapshot taken when a frame starts
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dist_reg   <= 16'h0000;
      amp_reg    <= 16'h0000;
      temp_reg   <= 16'h0000;
      ts_reg     <= 32'h0000_0000;
      tag_reg    <= 8'h00;
      txt_reg[0] <= 8'h00;
      txt_reg[1] <= 8'h00;
      txt_reg[2] <= 8'h00;
      txt_reg[3] <= 8'h00;
    end else if (start) begin
      dist_reg   <= is_mm ? meas_dist_mm_in : meas_dist_cm_in;
      amp_reg    <= amp_in;
      temp_reg   <= meas_temp_raw_in;
      ts_reg     <= meas_time_ms_in;
      tag_reg    <= {1'b0, cfg_i2c_addr_in};
      txt_reg[0] <= RFF_ASCII_0 + {4'h0, m_dig};
      txt_reg[1] <= RFF_ASCII_0 + {4'h0, tens_w[3:0]};
      txt_reg[2] <= RFF_ASCII_0 + {4'h0, ones_w[3:0]};
      txt_reg[3] <= 8'h00;
    end
  end

  rff_fifo #(.W(RFF_BYTE_W), .D(RFF_FIFO_DEPTH)) u_fifo (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr           (bus),
    .rd_valid_out (tx_valid_out),
    .rd_ready_in  (tx_ready_in),
    .rd_data_out  (tx_data_out)
  );
endmodule : rff_top
`default_nettype wire

// file: logic/rff_pkg.sv
// Package of constants and types for the range frame formatter
//
// Summary of operation
// - Nine-byte frame: 0x59 0x59, dist, strength, temp, sum
// - Temperature raw equals (celsius plus 256) times 8
// - Overexposure reported as strength 65535
// - Timestamp frame: 0x59 0x59, dist, strength, ts, sum
// - Timestamp in milliseconds, low byte first
// - Length-prefixed: 0x5A, len, 0, data, ts, sum
// - Eight-byte frame: dist, strength, ts; no header
// - Identifier frame adds unit tag before sum
// - Unit tag equals configured two-wire address
// - Text frame: metres, two decimals, terminator
// - Format code selects layout, default 0x01
// - Frames started only while output enabled
`default_nettype none
package rff_pkg;
  localparam logic [7:0] RFF_HDR_NINE  = 8'h59;
  localparam logic [7:0] RFF_HDR_LEN   = 8'h5A;
  localparam logic [7:0] RFF_ZERO_ID   = 8'h00;
  localparam logic [7:0] RFF_TERM_CHAR = 8'h0A;
  localparam logic [7:0] RFF_ASCII_0   = 8'h30;
  localparam logic [7:0] RFF_ASCII_DOT = 8'h2E;
  localparam logic [7:0] RFF_FMT_CM9   = 8'h01;
  localparam logic [7:0] RFF_FMT_TEXT  = 8'h02;
  localparam logic [7:0] RFF_FMT_MM9   = 8'h06;
  localparam logic [7:0] RFF_FMT_TS    = 8'h07;
  localparam logic [7:0] RFF_FMT_LEN   = 8'h08;
  localparam logic [7:0] RFF_FMT_EIGHT = 8'h09;
  localparam logic [7:0] RFF_FMT_TAG   = 8'h0A;
  localparam logic [7:0] RFF_FMT_RESET = RFF_FMT_CM9;
  localparam logic       RFF_EN_RESET  = 1'b1;
  localparam logic [15:0] RFF_OVEREXP  = 16'hFFFF;
  localparam logic [4:0] RFF_LEN_NINE  = 5'h09;
  localparam logic [4:0] RFF_LEN_TS    = 5'h0B;
  localparam logic [4:0] RFF_LEN_LP    = 5'h0C;
  localparam logic [4:0] RFF_LEN_EIGHT = 5'h08;
  localparam logic [4:0] RFF_LEN_TAG   = 5'h0D;
  localparam logic [4:0] RFF_LEN_TEXT  = 5'h06;
  localparam int         RFF_FIFO_DEPTH = 16;
  localparam int         RFF_BYTE_W     = 8;

  typedef enum logic [1:0] {
    RFF_IDLE = 2'b00,
    RFF_SEND = 2'b01
  } rff_state_e;
endpackage : rff_pkg
`default_nettype wire

// file: logic/rff_byte_if.sv
// Byte stream interface between the framer and its output FIFO
`default_nettype none
interface rff_byte_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : rff_byte_if
`default_nettype wire

// file: logic/rff_fifo.sv
// Byte FIFO with valid and ready on both sides
`default_nettype none
module rff_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  rff_byte_if.snk           wr,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in,
  output logic [W-1:0]      rd_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  wire full  = (wp_reg[AW] != rp_reg[AW]) &&
               (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire empty = (wp_reg == rp_reg);
  wire do_wr = wr.valid && !full;
  wire do_rd = rd_ready_in && !empty;
  assign wr.ready     = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rp_reg[AW-1:0]];

  always_ff @(posedge core_clk_in) begin
    if (do_wr) begin
      mem[wp_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule : rff_fifo
`default_nettype wire

// file: testbench/rff_top_sva.sv
// Assertion checker on the ports of the frame formatter top
`default_nettype none
module rff_top_sva (
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       meas_valid_in,
  input wire logic       meas_ready_out,
  input wire logic [7:0] cfg_format_in,
  input wire logic       cfg_format_we_in,
  input wire logic       cfg_out_en_in,
  input wire logic       cfg_out_en_we_in,
  input wire logic [7:0] cfg_format_out,
  input wire logic       cfg_out_en_out,
  input wire logic       tx_valid_out,
  input wire logic       tx_ready_in,
  input wire logic [7:0] tx_data_out,
  input wire logic       busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic take = meas_valid_in && meas_ready_out && cfg_out_en_out;
  wire logic known = cfg_format_in inside
    {8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
  sequence s_take;
    take ##1 busy_out;
  endsequence
  AST_TAKE: assert property (take |=> busy_out ##1 tx_valid_out)
    else $error("sample not framed");
  AST_REFUSE: assert property (
    meas_valid_in && !cfg_out_en_out && !busy_out |=> !busy_out)
    else $error("frame built while disabled");
  AST_QUIET: assert property (
    !busy_out && !tx_valid_out && !take |=> !tx_valid_out)
    else $error("byte without a frame");
  AST_FMT_SET: assert property (
    cfg_format_we_in && known |=> cfg_format_out == $past(cfg_format_in))
    else $error("format code not taken");
  AST_FMT_KEEP: assert property (
    cfg_format_we_in && !known |=> $stable(cfg_format_out))
    else $error("unknown format code taken");
  AST_EN_SET: assert property (
    cfg_out_en_we_in |=> cfg_out_en_out == $past(cfg_out_en_in))
    else $error("enable not taken");
  AST_HOLD: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
    else $error("byte lost while stalled");
  AST_FRAME: assert property (s_take |-> busy_out [*5])
    else $error("frame too short");
endmodule // rff_top_sva
bind rff_top rff_top_sva i_rff_top_sva (.*);
`default_nettype wire

// file: testbench/rff_host_model.sv
// Host model that takes frame bytes, stalling when asked to
`default_nettype none
module rff_host_model (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [1:0] tick_reg;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_reg <= 2'h0;
      tx_ready_out <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      // Slow host takes one byte in four cycles
      tx_ready_out <= !slow_in || tick_reg == 2'h3;
      // Bytes kept in order so the sum can be checked
      if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
    end
  end
endmodule // rff_host_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the range frame formatter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rff_pkg::*;
  logic core_clk_in = 0, sys_rst_in = 1, meas_valid_in = 0, busy_out;
  logic meas_overexp_in = 0, cfg_format_we_in = 0, cfg_out_en_we_in = 0;
  logic cfg_out_en_in = 1, slow = 0, meas_ready_out, cfg_out_en_out;
  logic tx_valid_out, tx_ready_in;
  logic [15:0] meas_dist_cm_in = 16'h0159, meas_dist_mm_in = 16'h0D7A;
  logic [15:0] meas_strength_in = 16'h0123;
  logic [15:0] meas_temp_raw_in = 16'h08C8; // Raw value of 25 C
  logic [31:0] meas_time_ms_in = 32'h12345678;
  logic [7:0] cfg_format_in = 8'h01, cfg_format_out, tx_data_out;
  logic [6:0] cfg_i2c_addr_in = 7'h2A;
  logic [7:0] exp_q[$];
  logic [7:0] fmts[7] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
  int errors = 0, n_compared = 0;
  always #50 core_clk_in = ~core_clk_in;
  rff_top i_rff_top (.*);
  rff_host_model i_rff_host_model (.core_clk_in, .sys_rst_in,
    .slow_in(slow), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task automatic push16(input logic [15:0] v);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
  endtask
  task automatic make_exp(input logic [7:0] f);
    logic [7:0] s;
    int b;
    b = exp_q.size();
    s = 8'h00;
    if (f == 8'h02) begin
      exp_q = {exp_q, 8'h33, 8'h2E, 8'h34, 8'h35, 8'h00, 8'h0A};
      return;
    end
    if (f == 8'h08 || f == 8'h0A)
      exp_q = {exp_q, 8'h5A, f == 8'h08 ? 8'h0C : 8'h0D, 8'h00};
    else if (f != 8'h09) exp_q = {exp_q, 8'h59, 8'h59};
    push16(f == 8'h06 ? meas_dist_mm_in : meas_dist_cm_in);
    push16(meas_overexp_in ? 16'hFFFF : meas_strength_in);
    if (f == 8'h01 || f == 8'h06) push16(meas_temp_raw_in);
    else begin
      push16(meas_time_ms_in[15:0]);
      push16(meas_time_ms_in[31:16]);
    end
    if (f == 8'h0A) exp_q.push_back({1'b0, cfg_i2c_addr_in});
    if (f == 8'h09) return;
    for (int i = b; i < exp_q.size(); i++) s += exp_q[i];
    exp_q.push_back(s);
  endtask
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 400 && busy_out !== v; k++) @(negedge core_clk_in);
    if (k == 400) begin
      errors++;
      finish_test();
    end
  endtask
  // Sends n frames back to back; a hard run overexposes and stalls
  task automatic run_frames(input logic [7:0] f, input int n,
                            input logic hard);
    exp_q.delete();
    i_rff_host_model.got.delete();
    @(posedge core_clk_in);
    cfg_format_in <= f;
    cfg_format_we_in <= 1'b1;
    meas_overexp_in <= hard;
    slow <= hard;
    cfg_i2c_addr_in <= hard ? 7'h55 : 7'h2A;
    @(posedge core_clk_in);
    cfg_format_we_in <= 1'b0;
    meas_valid_in <= 1'b1;
    for (int i = 0; i < n; i++) begin
      make_exp(f);
      wait_busy(1'b1);
      check(meas_ready_out, 1'b0);
      if (i == n - 1) begin
        @(posedge core_clk_in);
        meas_valid_in <= 1'b0;
      end
      wait_busy(1'b0);
    end
    for (int k = 0; k < 999 && (busy_out !== 1'b0 ||
                                tx_valid_out !== 1'b0); k++)
      @(negedge core_clk_in);
    if (busy_out !== 1'b0 || tx_valid_out !== 1'b0) begin
      errors++;
      finish_test();
    end
    check(cfg_format_out, f);
    check(i_rff_host_model.got.size(), exp_q.size());
    foreach (exp_q[j]) check(i_rff_host_model.got[j], exp_q[j]);
  endtask
  task automatic check_disabled;
    @(posedge core_clk_in);
    cfg_out_en_in <= 1'b0;
    cfg_out_en_we_in <= 1'b1;
    cfg_format_in <= 8'h03;
    cfg_format_we_in <= 1'b1;
    @(posedge core_clk_in);
    cfg_out_en_we_in <= 1'b0;
    cfg_format_we_in <= 1'b0;
    meas_valid_in <= 1'b1;
    repeat (20) @(negedge core_clk_in);
    check(busy_out, 1'b0);
    check(tx_valid_out, 1'b0);
    check(meas_ready_out, 1'b1);
    check(cfg_format_out, 8'h07);
    @(posedge core_clk_in);
    meas_valid_in <= 1'b0;
    cfg_out_en_in <= 1'b1;
    cfg_out_en_we_in <= 1'b1;
    @(posedge core_clk_in);
    cfg_out_en_we_in <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge core_clk_in);
    check(cfg_format_out, 8'h01);
    check(cfg_out_en_out, 1'b1);
    foreach (fmts[i]) run_frames(fmts[i], 1, 1'b0);
    run_frames(8'h0A, 2, 1'b1);
    run_frames(8'h07, 1, 1'b0);
    check_disabled();
    run_frames(8'h01, 1, 1'b0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
